// >>> logic/tai_pkg.sv
`default_nettype none
package tai_pkg;
   // Register byte offsets
   localparam logic [7:0] TAI_OFS_GROUP_EN = 8'h00;
   localparam logic [7:0] TAI_OFS_ALARM_STATUS = 8'h04;
   localparam logic [7:0] TAI_OFS_SRC_EN = 8'h08;
   localparam logic [7:0] TAI_OFS_IRQ_STATUS = 8'h0c;
   localparam logic [7:0] TAI_OFS_IRQ_MASK = 8'h10;
   localparam logic [7:0] TAI_OFS_BLOCK_STATUS = 8'h14;
   localparam logic [7:0] TAI_OFS_OOF_CFG = 8'h18;
   // Group enable bit positions
   localparam int TAI_BIT_SLIP_EN = 2;
   localparam int TAI_BIT_ALARM_EN = 1;
   localparam int TAI_BIT_FRAMER_EN = 0;
   // Alarm status bit positions, and the LCV enable bit in source enable
   localparam int TAI_BIT_OOF = 7;
   localparam int TAI_BIT_AIS = 6;
   localparam int TAI_BIT_YEL = 5;
   localparam int TAI_BIT_LOS = 4;
   localparam int TAI_BIT_LCV = 3;
   localparam int TAI_BIT_LCV_EN = 3;
   // Reset values
   localparam logic [7:0] TAI_RST_GROUP_EN = 8'h00;
   localparam logic [7:0] TAI_RST_SRC_EN = 8'h00;
   localparam logic [7:0] TAI_RST_OOF_CFG = 8'h24;
   // Timing
   localparam int TAI_CLK_HZ = 25000000;
   localparam int TAI_AIS_MS = 42;
   localparam int TAI_YEL_MS = 900;
   localparam int TAI_LOS_BITS = 175;
   localparam int TAI_AIS_CYC = TAI_CLK_HZ / 1000 * TAI_AIS_MS;
   localparam int TAI_YEL_CYC = TAI_CLK_HZ / 1000 * TAI_YEL_MS;
   // Ones density: one in eight bits
   localparam int TAI_DENS_DIV = 8;
   localparam logic [1:0] TAI_RESP_OKAY = 2'h0;
   localparam logic [1:0] TAI_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic oof;
      logic ais;
      logic rai;
      logic los;
      logic lcv;
      logic bit_en;
      logic bit_data;
   } tai_line_t;

   typedef struct packed {
      logic slip;
      logic alarm;
      logic framer;
   } tai_groups_t;
endpackage : tai_pkg
`default_nettype wire

// >>> logic/tai_persist.sv
`timescale 1ns/1ps
`default_nettype none
// Debounce: output follows input after it stays stable for a count; with FAST_CLR a low input clears it at once
module tai_persist
   import tai_pkg::*;
#(
   parameter int SET_CNT = TAI_AIS_CYC,
   parameter int CLR_CNT = TAI_AIS_CYC,
   parameter bit FAST_CLR = 1'b0
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tick,
   input wire logic level,
   output logic state
);
   typedef struct packed {
      logic [31:0] cnt;
      logic st;
   } tai_pst_t;

   tai_pst_t cur_ff;
   tai_pst_t nxt_cur;

   always_comb
   begin
      nxt_cur = cur_ff;
      if (FAST_CLR && !level)
      begin
         nxt_cur.st = 1'b0;
         nxt_cur.cnt = '0;
      end
      else if (level == cur_ff.st)
         nxt_cur.cnt = '0;
      else if (tick)
      begin
         if (cur_ff.cnt + 32'h1 >= 32'(cur_ff.st ? CLR_CNT : SET_CNT))
         begin
            nxt_cur.st = level;
            nxt_cur.cnt = '0;
         end
         else
            nxt_cur.cnt = cur_ff.cnt + 32'h1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cur_ff <= '0;
      else
         cur_ff <= nxt_cur;
   end

   assign state = cur_ff.st;
endmodule : tai_persist
`default_nettype wire

// >>> logic/tai_axil.sv
`timescale 1ns/1ps
`default_nettype none
// AXI4-Lite slave front end: one write and one read at a time
module tai_axil
   import tai_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data,
   input wire logic wr_ok,
   output logic rd_en,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);
   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [7:0] wdata;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } tai_ax_t;

   tai_ax_t cur_ff;
   tai_ax_t nxt_cur;

   assign s_axi_awready = !cur_ff.aw_got && !cur_ff.bvalid;
   assign s_axi_wready = !cur_ff.w_got && !cur_ff.bvalid;
   assign s_axi_arready = !cur_ff.rvalid;
   assign wr_en = cur_ff.aw_got && cur_ff.w_got;
   assign wr_addr = cur_ff.awaddr;
   assign wr_data = cur_ff.wdata;
   assign rd_en = s_axi_arvalid && s_axi_arready;
   assign rd_addr = s_axi_araddr;

   always_comb
   begin
      nxt_cur = cur_ff;
      if (s_axi_awvalid && s_axi_awready)
      begin
         nxt_cur.aw_got = 1'b1;
         nxt_cur.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         nxt_cur.w_got = 1'b1;
         nxt_cur.wdata = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end
      if (wr_en)
      begin
         nxt_cur.aw_got = 1'b0;
         nxt_cur.w_got = 1'b0;
         nxt_cur.bvalid = 1'b1;
         nxt_cur.bresp = wr_ok ? TAI_RESP_OKAY : TAI_RESP_SLVERR;
      end
      if (cur_ff.bvalid && s_axi_bready)
         nxt_cur.bvalid = 1'b0;
      if (rd_en)
      begin
         nxt_cur.rvalid = 1'b1;
         nxt_cur.rdata = rd_data;
         nxt_cur.rresp = rd_ok ? TAI_RESP_OKAY : TAI_RESP_SLVERR;
      end
      else if (cur_ff.rvalid && s_axi_rready)
         nxt_cur.rvalid = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cur_ff <= '0;
      else
         cur_ff <= nxt_cur;
   end

   assign s_axi_bvalid = cur_ff.bvalid;
   assign s_axi_bresp = cur_ff.bresp;
   assign s_axi_rvalid = cur_ff.rvalid;
   assign s_axi_rresp = cur_ff.rresp;
   assign s_axi_rdata = cur_ff.rdata;

   chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_en |=> s_axi_bvalid)
      else $error("write not answered");
   chk_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_en |=> s_axi_rvalid && s_axi_rdata == $past(rd_data))
      else $error("read data not returned");
endmodule : tai_axil
`default_nettype wire

// >>> logic/tai_top.sv
`timescale 1ns/1ps
`default_nettype none
module tai_top
   import tai_pkg::*;
#(
   parameter int AIS_CYC = TAI_AIS_CYC,
   parameter int YEL_CYC = TAI_YEL_CYC,
   parameter int LOS_BITS = TAI_LOS_BITS
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire tai_line_t line_in,
   input wire logic slip_irq_req,
   input wire logic framer_irq_req,
   output logic irq
);
   typedef struct packed {
      logic [7:0] group_en;
      logic [7:0] src_en;
      logic [7:0] oof_cfg;
      logic lcv_flag;
      logic [2:0] irq_sts;
      logic [2:0] irq_msk;
      logic alarm_pend;
      logic [3:0] fe_win_cnt;
      logic [3:0] fe_err_cnt;
      logic oof;
      logic [7:0] los_cnt;
      logic [7:0] ones_cnt;
      logic [7:0] dens_cnt;
      logic los;
      logic irq;
   } tai_st_t;

   tai_st_t cur_ff;
   tai_st_t nxt_cur;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_ok;
   logic rd_en;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_ok;
   logic ais_st;
   logic yel_st;
   logic [7:0] alarm_view;
   tai_groups_t grp_req;
   logic [2:0] ev;

   function automatic logic known_addr(input logic [7:0] a);
      return a == TAI_OFS_GROUP_EN || a == TAI_OFS_ALARM_STATUS ||
         a == TAI_OFS_SRC_EN || a == TAI_OFS_IRQ_STATUS ||
         a == TAI_OFS_IRQ_MASK || a == TAI_OFS_BLOCK_STATUS ||
         a == TAI_OFS_OOF_CFG;
   endfunction : known_addr

   tai_axil u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_ok(wr_ok),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   // AIS needs 42 ms both ways
   tai_persist #(.SET_CNT(AIS_CYC), .CLR_CNT(AIS_CYC), .FAST_CLR(1'b0))
      u_ais (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(1'b1),
      .level(line_in.ais),
      .state(ais_st)
   );

   // Yellow sets after 900 ms, drops at once
   tai_persist #(.SET_CNT(YEL_CYC), .CLR_CNT(1), .FAST_CLR(1'b1))
      u_yel (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(1'b1),
      .level(line_in.rai),
      .state(yel_st)
   );

   assign alarm_view = {cur_ff.oof, ais_st, yel_st, cur_ff.los,
      cur_ff.lcv_flag, 3'h0};
   assign wr_ok = known_addr(wr_addr);
   assign rd_ok = known_addr(rd_addr);
   assign grp_req.slip = slip_irq_req &&
      cur_ff.group_en[TAI_BIT_SLIP_EN];
   assign grp_req.alarm = cur_ff.alarm_pend &&
      cur_ff.group_en[TAI_BIT_ALARM_EN];
   assign grp_req.framer = framer_irq_req &&
      cur_ff.group_en[TAI_BIT_FRAMER_EN];
   assign ev = {grp_req.slip, grp_req.alarm, grp_req.framer};

   always_comb
   begin
      rd_data = 32'h0;
      unique case (rd_addr)
         TAI_OFS_GROUP_EN: rd_data[7:0] = cur_ff.group_en;
         TAI_OFS_ALARM_STATUS: rd_data[7:0] = alarm_view;
         TAI_OFS_SRC_EN: rd_data[7:0] = cur_ff.src_en;
         TAI_OFS_IRQ_STATUS: rd_data[2:0] = cur_ff.irq_sts;
         TAI_OFS_IRQ_MASK: rd_data[2:0] = cur_ff.irq_msk;
         TAI_OFS_BLOCK_STATUS: rd_data[2:0] = {slip_irq_req,
            cur_ff.alarm_pend, framer_irq_req};
         TAI_OFS_OOF_CFG: rd_data[7:0] = cur_ff.oof_cfg;
         default: rd_data = 32'h0;
      endcase
   end

   always_comb
   begin
      nxt_cur = cur_ff;
      if (wr_en)
      begin
         unique case (wr_addr)
            TAI_OFS_GROUP_EN: nxt_cur.group_en = wr_data & 8'h07;
            TAI_OFS_SRC_EN: nxt_cur.src_en = wr_data & 8'h08;
            TAI_OFS_IRQ_STATUS: nxt_cur.irq_sts = cur_ff.irq_sts &
               ~wr_data[2:0];
            TAI_OFS_IRQ_MASK: nxt_cur.irq_msk = wr_data[2:0];
            TAI_OFS_OOF_CFG: nxt_cur.oof_cfg = wr_data;
            default: nxt_cur.group_en = cur_ff.group_en;
         endcase
      end
      // Read of alarm status clears flag and pending
      if (rd_en && rd_addr == TAI_OFS_ALARM_STATUS)
      begin
         nxt_cur.lcv_flag = 1'b0;
         nxt_cur.alarm_pend = 1'b0;
      end
      // New violation wins over read clear
      if (line_in.lcv)
      begin
         nxt_cur.lcv_flag = 1'b1;
         if (cur_ff.src_en[TAI_BIT_LCV_EN])
            nxt_cur.alarm_pend = 1'b1;
      end
      // Framing errors: threshold in low nibble, window in high
      if (line_in.bit_en)
      begin
         if (cur_ff.fe_win_cnt + 4'h1 >= cur_ff.oof_cfg[7:4])
         begin
            nxt_cur.fe_win_cnt = 4'h0;
            nxt_cur.fe_err_cnt = 4'h0;
         end
         else
            nxt_cur.fe_win_cnt = cur_ff.fe_win_cnt + 4'h1;
         if (line_in.oof)
         begin
            if (cur_ff.fe_err_cnt + 4'h1 >= cur_ff.oof_cfg[3:0])
            begin
               nxt_cur.oof = 1'b1;
               nxt_cur.fe_err_cnt = 4'h0;
            end
            else
               nxt_cur.fe_err_cnt = cur_ff.fe_err_cnt + 4'h1;
         end
         else if (cur_ff.fe_win_cnt == 4'h0 && cur_ff.fe_err_cnt == 4'h0)
            nxt_cur.oof = 1'b0;
      end
      // Loss of signal per received bit
      if (!line_in.los)
      begin
         nxt_cur.los = 1'b0;
         nxt_cur.los_cnt = 8'h0;
         nxt_cur.ones_cnt = 8'h0;
         nxt_cur.dens_cnt = 8'h0;
      end
      else if (line_in.bit_en)
      begin
         if (cur_ff.los_cnt + 8'h1 >= 8'(LOS_BITS))
            nxt_cur.los = 1'b1;
         else
            nxt_cur.los_cnt = cur_ff.los_cnt + 8'h1;
         nxt_cur.ones_cnt = cur_ff.ones_cnt + 8'(line_in.bit_data);
         if (cur_ff.dens_cnt + 8'h1 >= 8'(LOS_BITS))
         begin
            if (cur_ff.ones_cnt + 8'(line_in.bit_data) >=
               8'(LOS_BITS / TAI_DENS_DIV))
            begin
               nxt_cur.los = 1'b0;
               nxt_cur.los_cnt = 8'h0;
            end
            nxt_cur.dens_cnt = 8'h0;
            nxt_cur.ones_cnt = 8'h0;
         end
         else
            nxt_cur.dens_cnt = cur_ff.dens_cnt + 8'h1;
      end
      nxt_cur.irq_sts = nxt_cur.irq_sts | ev;
      nxt_cur.irq = |(cur_ff.irq_sts & cur_ff.irq_msk) ||
         |ev;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cur_ff <= '0;
         cur_ff.group_en <= TAI_RST_GROUP_EN;
         cur_ff.src_en <= TAI_RST_SRC_EN;
         cur_ff.oof_cfg <= TAI_RST_OOF_CFG;
      end
      else
         cur_ff <= nxt_cur;
   end

   assign irq = cur_ff.irq;

   chk_slip_gate: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !cur_ff.group_en[TAI_BIT_SLIP_EN] &&
      !cur_ff.irq_sts[TAI_BIT_SLIP_EN] |=>
      !cur_ff.irq_sts[TAI_BIT_SLIP_EN])
      else $error("slip passes disabled group");
   chk_alarm_gate: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !cur_ff.group_en[TAI_BIT_ALARM_EN] &&
      !cur_ff.irq_sts[TAI_BIT_ALARM_EN] |=>
      !cur_ff.irq_sts[TAI_BIT_ALARM_EN])
      else $error("alarm passes disabled group");
   chk_framer_gate: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !cur_ff.group_en[TAI_BIT_FRAMER_EN] &&
      !cur_ff.irq_sts[TAI_BIT_FRAMER_EN] |=>
      !cur_ff.irq_sts[TAI_BIT_FRAMER_EN])
      else $error("framer passes disabled group");
   chk_lcv_sticky: assert property (
      @(posedge aclk) disable iff (!aresetn)
      line_in.lcv
      |=> cur_ff.lcv_flag)
      else $error("violation flag not set");
   chk_lcv_gate: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !cur_ff.alarm_pend && !cur_ff.src_en[TAI_BIT_LCV_EN]
      |=> !cur_ff.alarm_pend)
      else $error("pending without enable");
   chk_pend_clear: assert property (
      @(posedge aclk) disable iff (!aresetn)
      rd_en && rd_addr == TAI_OFS_ALARM_STATUS && !line_in.lcv
      |=> !cur_ff.alarm_pend)
      else $error("pending not cleared by read");
   chk_yel_drop: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !line_in.rai
      |=> !yel_st)
      else $error("yellow not cleared at once");
   chk_los_clear: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !line_in.los
      |=> !cur_ff.los)
      else $error("loss not cleared");
   chk_los_cause: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !cur_ff.los && !(line_in.los && line_in.bit_en)
      |=> !cur_ff.los)
      else $error("loss declared without a lost bit");
   chk_oof_cause: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !cur_ff.oof && !(line_in.oof && line_in.bit_en)
      |=> !cur_ff.oof)
      else $error("out of frame without framing error");
   chk_irq_cause: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !(|ev) && !(|(cur_ff.irq_sts & cur_ff.irq_msk))
      |=> !irq)
      else $error("interrupt without enabled cause");
   chk_irq_follow: assert property (
      @(posedge aclk) disable iff (!aresetn)
      |ev
      |=> irq)
      else $error("interrupt not raised");
endmodule : tai_top
`default_nettype wire

// >>> test/tai_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
   begin \
      tests_run++; \
      if ((g) !== (e)) \
      begin \
         n_fail++; \
         $display("ERROR %s exp %0h got %0h", nm, e, g); \
      end \
   end
module tb
   import tai_pkg::*;
;
   localparam int AIS_N = 20;
   localparam int YEL_N = 40;
   localparam int LOS_N = 10;
   localparam logic [1:0] OK = TAI_RESP_OKAY;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   tai_line_t line_in = '0;
   logic slip_irq_req = 1'b0;
   logic framer_irq_req = 1'b0;
   logic irq;
   int n_fail = 0;
   int tests_run = 0;

   always #20 aclk = ~aclk;

   tai_top #(.AIS_CYC(AIS_N), .YEL_CYC(YEL_N), .LOS_BITS(LOS_N)) i_tai_top (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .line_in, .slip_irq_req,
      .framer_irq_req, .irq
   );

   task automatic conclude;
      $display("checks %0d errors %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude

   task automatic tmo;
      n_fail++;
      $display("ERROR bus wait exp answer got none");
      conclude();
   endtask : tmo

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : cyc

   // Write one register; both channels offered together
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er);
      int i;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1)
            break;
      end
      if (i == 20)
         tmo();
      s_axi_bready <= 1'b0;
      `CHK("bresp", er, s_axi_bresp)
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     input logic [1:0] er);
      int i;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1)
            break;
      end
      if (i == 20)
         tmo();
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
      `CHK("rresp", er, s_axi_rresp)
   endtask : rd

   task automatic lcv_pulse;
      @(posedge aclk);
      line_in.lcv <= 1'b1;
      @(posedge aclk);
      line_in.lcv <= 1'b0;
      cyc(3);
   endtask : lcv_pulse

   // One received bit every two clocks
   task automatic bits(input int n);
      repeat (n)
      begin
         @(posedge aclk);
         line_in.bit_en <= 1'b1;
         @(posedge aclk);
         line_in.bit_en <= 1'b0;
      end
   endtask : bits

   task automatic t_reset;
      logic [31:0] d;
      `CHK("irq", 1'b0, irq)
      rd(TAI_OFS_GROUP_EN, d, OK);
      `CHK("group_en", {24'h0, TAI_RST_GROUP_EN}, d)
      rd(TAI_OFS_ALARM_STATUS, d, OK);
      `CHK("alarm_status", 32'h0, d)
      rd(TAI_OFS_OOF_CFG, d, OK);
      `CHK("oof_cfg", {24'h0, TAI_RST_OOF_CFG}, d)
      rd(8'h20, d, TAI_RESP_SLVERR);
      wr(8'h1c, 8'hff, TAI_RESP_SLVERR);
      wr(TAI_OFS_IRQ_MASK, 8'h07, OK);
   endtask : t_reset

   task automatic t_group(input int b);
      logic [31:0] d;
      if (b == TAI_BIT_SLIP_EN)
         slip_irq_req <= 1'b1;
      else
         framer_irq_req <= 1'b1;
      cyc(4);
      `CHK("irq blocked", 1'b0, irq)
      wr(TAI_OFS_GROUP_EN, 8'h01 << b, OK);
      cyc(3);
      `CHK("irq open", 1'b1, irq)
      rd(TAI_OFS_IRQ_STATUS, d, OK);
      `CHK("irq_status", 32'h1 << b, d)
      slip_irq_req <= 1'b0;
      framer_irq_req <= 1'b0;
      cyc(3);
      `CHK("irq sticky", 1'b1, irq)
      wr(TAI_OFS_IRQ_MASK, 8'h00, OK);
      cyc(3);
      `CHK("irq masked", 1'b0, irq)
      wr(TAI_OFS_IRQ_MASK, 8'h07, OK);
      wr(TAI_OFS_IRQ_STATUS, 8'h01 << b, OK);
      cyc(3);
      `CHK("irq cleared", 1'b0, irq)
      wr(TAI_OFS_GROUP_EN, 8'h00, OK);
   endtask : t_group

   task automatic t_lcv;
      logic [31:0] d;
      wr(TAI_OFS_GROUP_EN, 8'h02, OK);
      lcv_pulse();
      `CHK("irq src off", 1'b0, irq)
      rd(TAI_OFS_ALARM_STATUS, d, OK);
      `CHK("lcv set", 1'b1, d[TAI_BIT_LCV])
      rd(TAI_OFS_ALARM_STATUS, d, OK);
      `CHK("lcv read clr", 1'b0, d[TAI_BIT_LCV])
      wr(TAI_OFS_GROUP_EN, 8'h00, OK);
      wr(TAI_OFS_SRC_EN, 8'h08, OK);
      lcv_pulse();
      `CHK("irq grp off", 1'b0, irq)
      rd(TAI_OFS_ALARM_STATUS, d, OK);
      rd(TAI_OFS_IRQ_STATUS, d, OK);
      `CHK("alarm irq_status", 1'b0, d[1])
      wr(TAI_OFS_GROUP_EN, 8'h02, OK);
      lcv_pulse();
      `CHK("irq lcv", 1'b1, irq)
      rd(TAI_OFS_BLOCK_STATUS, d, OK);
      `CHK("pending", 1'b1, d[1])
      rd(TAI_OFS_ALARM_STATUS, d, OK);
      rd(TAI_OFS_BLOCK_STATUS, d, OK);
      `CHK("pending clr", 1'b0, d[1])
      wr(TAI_OFS_IRQ_STATUS, 8'h02, OK);
      cyc(3);
      `CHK("irq lcv clr", 1'b0, irq)
   endtask : t_lcv

   task automatic t_persist;
      logic [31:0] d;
      line_in.ais <= 1'b1;
      cyc(AIS_N - 6);
      rd(TAI_OFS_ALARM_STATUS, d, OK);
      `CHK("ais early", 1'b0, d[TAI_BIT_AIS])
      cyc(10);
      rd(TAI_OFS_ALARM_STATUS, d, OK);
      `CHK("ais set", 1'b1, d[TAI_BIT_AIS])
      line_in.ais <= 1'b0;
      cyc(AIS_N - 6);
      rd(TAI_OFS_ALARM_STATUS, d, OK);
      `CHK("ais held", 1'b1, d[TAI_BIT_AIS])
      cyc(10);
      rd(TAI_OFS_ALARM_STATUS, d, OK);
      `CHK("ais clr", 1'b0, d[TAI_BIT_AIS])
      line_in.rai <= 1'b1;
      cyc(YEL_N - 6);
      rd(TAI_OFS_ALARM_STATUS, d, OK);
      `CHK("yel early", 1'b0, d[TAI_BIT_YEL])
      cyc(10);
      rd(TAI_OFS_ALARM_STATUS, d, OK);
      `CHK("yel set", 1'b1, d[TAI_BIT_YEL])
      line_in.rai <= 1'b0;
      rd(TAI_OFS_ALARM_STATUS, d, OK);
      `CHK("yel clr", 1'b0, d[TAI_BIT_YEL])
   endtask : t_persist

   task automatic t_bits;
      logic [31:0] d;
      line_in.los <= 1'b1;
      bits(LOS_N - 3);
      rd(TAI_OFS_ALARM_STATUS, d, OK);
      `CHK("los early", 1'b0, d[TAI_BIT_LOS])
      bits(6);
      rd(TAI_OFS_ALARM_STATUS, d, OK);
      `CHK("los set", 1'b1, d[TAI_BIT_LOS])
      line_in.los <= 1'b0;
      cyc(4);
      rd(TAI_OFS_ALARM_STATUS, d, OK);
      `CHK("los clr", 1'b0, d[TAI_BIT_LOS])
      // Dense ones keep loss cleared
      line_in.los <= 1'b1;
      line_in.bit_data <= 1'b1;
      bits(LOS_N + 3);
      rd(TAI_OFS_ALARM_STATUS, d, OK);
      `CHK("los dense", 1'b0, d[TAI_BIT_LOS])
      line_in.los <= 1'b0;
      line_in.bit_data <= 1'b0;
      // Threshold 2 errors in an 8-bit window
      wr(TAI_OFS_OOF_CFG, 8'h82, OK);
      line_in.oof <= 1'b1;
      bits(1);
      rd(TAI_OFS_ALARM_STATUS, d, OK);
      `CHK("oof below", 1'b0, d[TAI_BIT_OOF])
      bits(2);
      rd(TAI_OFS_ALARM_STATUS, d, OK);
      `CHK("oof set", 1'b1, d[TAI_BIT_OOF])
      line_in.oof <= 1'b0;
      bits(20);
      rd(TAI_OFS_ALARM_STATUS, d, OK);
      `CHK("oof clr", 1'b0, d[TAI_BIT_OOF])
   endtask : t_bits

   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_group(TAI_BIT_SLIP_EN);
      t_group(TAI_BIT_FRAMER_EN);
      t_lcv();
      t_persist();
      t_bits();
      conclude();
   end
endmodule : tb
`default_nettype wire
